// ---- shared/dafs_pkg.sv ----
// Package for the domain access and data fault status block.
package dafs_pkg;

   // ********************************************************************
   // Register selection and widths.
   // ********************************************************************
   localparam int unsigned DOMAINS     = 16;
   localparam int unsigned DOM_W       = 4;
   localparam int unsigned PERM_W      = 2;
   localparam int unsigned REG_W       = 32;
   localparam logic [31:0] DOMPERM_RST = 32'h0000_0000;
   localparam logic [31:0] FAULT_RST   = 32'h0000_0000;

   typedef enum logic [1:0] {
      DAFS_REG_DOMPERM = 2'h0,
      DAFS_REG_FAULT   = 2'h1,
      DAFS_REG_NONE    = 2'h2
   } dafs_reg_sel_t;

   // ********************************************************************
   // Domain permission codes.
   // ********************************************************************
   localparam logic [1:0] PERM_NOACC   = 2'h0;
   localparam logic [1:0] PERM_CLIENT  = 2'h1;
   localparam logic [1:0] PERM_RSVD    = 2'h2;
   localparam logic [1:0] PERM_MANAGER = 2'h3;

   // ********************************************************************
   // Fault record field positions.
   // ********************************************************************
   localparam int unsigned FS_STAT_LO = 0;
   localparam int unsigned FS_STAT_HI = 3;
   localparam int unsigned FS_DOM_LO  = 4;
   localparam int unsigned FS_DOM_HI  = 7;
   localparam int unsigned FS_EXT     = 10;
   localparam int unsigned FS_WNR     = 11;
   localparam int unsigned FS_BUSERR  = 12;
   localparam logic [31:0] FS_WMASK   = 32'h0000_1CFF;
   localparam logic [31:0] FS_IMPMASK = 32'h0000_000F;

   // ********************************************************************
   // Carriers.
   // ********************************************************************
   typedef struct packed {
      logic          valid;
      logic          write;
      dafs_reg_sel_t sel;
      logic          secure;
      logic          priv;
      logic [31:0]   wdata;
   } dafs_reg_req_t;

   typedef struct packed {
      logic             valid;
      logic [DOM_W-1:0] domain;
      logic [1:0]       ap_ok;
      logic             fetch;
      logic             no_execute_attribute;
   } dafs_chk_req_t;

   typedef struct packed {
      logic             valid;
      logic             secure;
      logic             imprecise;
      logic             external;
      logic             bus_error_kind;
      logic             write;
      logic             status_ext;
      logic [3:0]       status;
      logic [DOM_W-1:0] domain;
   } dafs_abort_t;

endpackage

// ---- rtl/dafs_top.sv ----
// Domain permission register, data fault record and access check.
//
// Contract
// RL1: Sixteen 2-bit domain fields in one register, field n at bits 2n+1:2n.
// RL2: No-access code raises a domain fault on every access.
// RL3: Client code checks the access against TLB permission bits.
// RL4: Reserved code behaves as no access, raising a domain fault.
// RL5: Manager code skips permission check; no permission fault.
// RL6: Manager domain fetch from no-execute page does not abort.
// RL7: Secure and nonsecure copies; accesses reach the current state's copy.
// RL8: User-mode reads or writes raise undefined instruction, no data moved.
// RL9: Lock high blocks secure privileged permission writes with undefined.
// RL10: Each data abort replaces the current state's fault record.
// RL11: Imprecise aborts record only the low four status bits.
// RL12: Bit 12 shows bus error kind for external aborts, else zero.
// RL13: Bit 11 records read or write direction, reset zero.
// RL14: Bit 10 is an extra status bit, reset zero.
// RL15: Bits 7:4 record the faulting domain number.
// RL16: Bits 9:8 read zero and ignore writes.
// RL17: Permission field is chosen by the TLB entry's domain number.
`timescale 1ns/1ps
module dafs_top
   import dafs_pkg::*;
(
   // Clock and reset.
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          clk_en,
   // Lock pin from outside the clock domain.
   input  wire logic          secure_register_write_lock,
   // Privileged register access.
   input  wire dafs_reg_req_t reg_req,
   output logic               reg_undef,
   output logic               reg_rvalid,
   output logic [31:0]        reg_rdata,
   // Access check.
   input  wire dafs_chk_req_t chk_req,
   output logic               chk_valid,
   output logic               chk_domain_fault,
   output logic               chk_perm_fault,
   output logic               chk_xn_fault,
   // Data abort capture.
   input  wire dafs_abort_t   abort_in
);

   // ********************************************************************
   // Lock synchroniser.
   // ********************************************************************
   // The lock pin is asynchronous to ref_clk, so two flops settle it before the
   // decode reads it. A write within two cycles of a change still sees the old level.
   logic lock_meta;
   logic lock_sync;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
      end else if (clk_en) begin
         lock_meta <= secure_register_write_lock;
         lock_sync <= lock_meta;
      end
   end

   // ********************************************************************
   // Decode helpers.
   // ********************************************************************
   // Field d of a permission copy sits at bits 2d+1:2d.
   function automatic logic [1:0] perm_of(input logic [31:0] r, input logic [DOM_W-1:0] d);
      perm_of = r[{d, 1'b0} +: PERM_W]; // RL1 RL17
   endfunction

   // Register select compare, shared by the write, read and refusal decode.
   function automatic logic sel_is(input dafs_reg_sel_t s, input dafs_reg_sel_t t);
      sel_is = (s == t);
   endfunction

   // ********************************************************************
   // Register access decode.
   // ********************************************************************
   // Every privileged access reaches the copy of its own security state.
   wire logic bank       = reg_req.secure; // RL7
   wire logic is_dom     = sel_is(reg_req.sel, DAFS_REG_DOMPERM);
   wire logic is_fault   = sel_is(reg_req.sel, DAFS_REG_FAULT);
   wire logic is_none    = sel_is(reg_req.sel, DAFS_REG_NONE);
   wire logic priv_req   = reg_req.valid && reg_req.priv;

   // User mode never reaches either register, whatever it selects.
   wire logic user_acc   = reg_req.valid && !reg_req.priv; // RL8

   // The lock guards only secure privileged writes of the permission copy.
   wire logic lock_block = priv_req && reg_req.write && reg_req.secure
                           && lock_sync && is_dom; // RL9
   wire logic unmapped   = priv_req && is_none;
   wire logic acc_ok     = priv_req && !lock_block && !unmapped;
   wire logic wr_dom     = acc_ok && reg_req.write && is_dom;
   wire logic wr_fault   = acc_ok && reg_req.write && is_fault;
   wire logic rd_any     = acc_ok && !reg_req.write;

   // ********************************************************************
   // Abort record build.
   // ********************************************************************
   // An imprecise abort leaves only the status bits meaningful, so every other
   // field is cleared rather than left to hold a guess.
   wire logic             precise    = !abort_in.imprecise; // RL11
   wire logic [3:0]       rec_status = abort_in.status; // RL10
   wire logic [DOM_W-1:0] rec_domain = precise ? abort_in.domain : '0; // RL15
   wire logic             rec_ext    = precise && abort_in.status_ext; // RL14
   wire logic             rec_wnr    = precise && abort_in.write; // RL13
   // The bus error kind only means something for an external abort.
   wire logic             rec_buserr = precise && abort_in.external
                                       && abort_in.bus_error_kind; // RL12
   logic [31:0] abort_word;

   always_comb begin
      abort_word                        = FAULT_RST;
      abort_word[FS_STAT_HI:FS_STAT_LO] = rec_status;
      abort_word[FS_DOM_HI:FS_DOM_LO]   = rec_domain;
      abort_word[FS_EXT]                = rec_ext;
      abort_word[FS_WNR]                = rec_wnr;
      abort_word[FS_BUSERR]             = rec_buserr;
   end

   // ********************************************************************
   // Banked registers.
   // ********************************************************************
   // One copy per security state; index 1 is the secure copy.
   logic [31:0] domperm [2];
   logic [31:0] fault   [2];

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         wire logic sel_b = (bank == 1'(b));
         wire logic ab_b  = abort_in.valid && (abort_in.secure == 1'(b));

         // Permission copy of this security state.
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               domperm[b] <= DOMPERM_RST;
            end else if (clk_en && wr_dom && sel_b) begin
               domperm[b] <= reg_req.wdata; // RL7
            end
         end

         // Hardware abort capture wins over a same-cycle software write, so a
         // fault is never lost to a handler that is clearing the record.
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               fault[b] <= FAULT_RST;
            end else if (clk_en) begin
               if (ab_b) begin
                  fault[b] <= abort_word; // RL10
               end else if (wr_fault && sel_b) begin
                  fault[b] <= reg_req.wdata & FS_WMASK; // RL16
               end
            end
         end
      end
   endgenerate

   // ********************************************************************
   // Per-domain permission view.
   // ********************************************************************
   // Both copies laid out field by field, so the check simply indexes them.
   logic [PERM_W-1:0] dom_field [2][DOMAINS];

   genvar n;
   generate
      for (n = 0; n < DOMAINS; n++) begin : g_field
         assign dom_field[0][n] = perm_of(domperm[0], DOM_W'(n)); // RL1
         assign dom_field[1][n] = perm_of(domperm[1], DOM_W'(n)); // RL1
      end
   endgenerate

   // ********************************************************************
   // Read path and undefined answer.
   // ********************************************************************
   // Read data is zero outside a read answer, so a refused request never
   // sees a stale word from an earlier read.
   wire logic [31:0] rd_mux     = is_dom ? domperm[bank] : fault[bank];
   wire logic [31:0] next_rdata = rd_any ? rd_mux : '0; // RL8
   wire logic        next_undef = user_acc || lock_block || unmapped; // RL8 RL9

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rvalid <= 1'b0;
         reg_rdata  <= '0;
         reg_undef  <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= rd_any;
         reg_rdata  <= next_rdata;
         reg_undef  <= next_undef;
      end
   end

   // ********************************************************************
   // Access check against the current state's permission copy.
   // ********************************************************************
   // The check reads the copy of the state the core runs in, which the state
   // bit of the abort port carries.
   wire logic [1:0] chk_perm    = dom_field[abort_in.secure][chk_req.domain]; // RL17
   wire logic       is_mgr      = (chk_perm == PERM_MANAGER);
   wire logic       is_client   = (chk_perm == PERM_CLIENT);
   wire logic       dom_f       = (chk_perm == PERM_NOACC) || (chk_perm == PERM_RSVD); // RL2 RL4
   wire logic       ap_denied   = !chk_req.ap_ok[0];
   wire logic       xn_hit      = chk_req.fetch && chk_req.no_execute_attribute;

   // A manager domain skips the entry's permission bits, no-execute included,
   // so neither a permission fault nor a no-execute fault can come from it.
   wire logic       next_dom_f  = chk_req.valid && dom_f; // RL2 RL4
   wire logic       next_perm_f = chk_req.valid && is_client && ap_denied && !is_mgr; // RL3 RL5
   wire logic       next_xn_f   = chk_req.valid && xn_hit && is_client; // RL6

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_valid        <= 1'b0;
         chk_domain_fault <= 1'b0;
         chk_perm_fault   <= 1'b0;
         chk_xn_fault     <= 1'b0;
      end else if (clk_en) begin
         chk_valid        <= chk_req.valid;
         chk_domain_fault <= next_dom_f;
         chk_perm_fault   <= next_perm_f;
         chk_xn_fault     <= next_xn_f;
      end
   end

endmodule // dafs_top

// ---- tb/dafs_chk.sv ----
// Assertion checker for the domain access and fault record block.
`timescale 1ns/1ps
module dafs_chk
   import dafs_pkg::*;
(
   // Clock and reset.
   input wire logic          ref_clk,
   input wire logic          rst_n,
   input wire logic          clk_en,
   // Register access.
   input wire dafs_reg_req_t reg_req,
   input wire logic          reg_undef,
   input wire logic          reg_rvalid,
   input wire logic [31:0]   reg_rdata,
   // Access check.
   input wire dafs_chk_req_t chk_req,
   input wire logic          chk_valid,
   input wire logic          chk_domain_fault,
   input wire logic          chk_perm_fault,
   input wire logic          chk_xn_fault
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire rq = clk_en && reg_req.valid;
   wire rd_ok = rq && reg_req.priv && !reg_req.write && reg_req.sel != DAFS_REG_NONE;
   a_user_undef: assert property (rq && !reg_req.priv |=> reg_undef && !reg_rvalid)
      else $error("user access not refused");
   a_read_answer: assert property (rd_ok |=> reg_rvalid && !reg_undef)
      else $error("privileged read not answered");
   a_undef_nodata: assert property (!reg_rvalid |-> reg_rdata == 32'h0000_0000)
      else $error("read data without answer");
   a_chk_answer: assert property (clk_en && chk_req.valid |=> chk_valid)
      else $error("check not answered");
   a_domain_only: assert property (chk_domain_fault |-> !chk_perm_fault && !chk_xn_fault)
      else $error("domain fault mixed with other faults");
   a_perm_cause: assert property (chk_perm_fault |-> chk_valid && !$past(chk_req.ap_ok[0]))
      else $error("permission fault on permitted access");
   a_xn_cause: assert property (chk_xn_fault |->
      $past(chk_req.fetch && chk_req.no_execute_attribute))
      else $error("no-execute fault without fetch");
   a_rsvd_zero: assert property (reg_rvalid && $past(reg_req.sel) == DAFS_REG_FAULT
      |-> reg_rdata[31:13] == '0 && reg_rdata[9:8] == 2'h0)
      else $error("reserved fault bits set");
   cover property (chk_domain_fault);
   cover property (chk_perm_fault);
   cover property (reg_undef);
endmodule // dafs_chk

bind dafs_top dafs_chk i_dafs_chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
   .reg_req(reg_req), .reg_undef(reg_undef), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
   .chk_req(chk_req), .chk_valid(chk_valid), .chk_domain_fault(chk_domain_fault),
   .chk_perm_fault(chk_perm_fault), .chk_xn_fault(chk_xn_fault));

// ---- tb/dafs_cpu.sv ----
// Processor pipeline model issuing privileged and user-mode register accesses.
`timescale 1ns/1ps
module dafs_cpu
   import dafs_pkg::*;
(
   // Clock.
   input  wire logic        ref_clk,
   // Request and answer.
   output dafs_reg_req_t    reg_req,
   input  wire logic        reg_undef,
   input  wire logic [31:0] reg_rdata
);
   initial reg_req = '0;
   // One valid cycle per access; the answer is sampled in the following cycle.
   task automatic acc(input logic w, input dafs_reg_sel_t s, input logic sec, input logic pv,
                      input logic [31:0] wd, output logic u, output logic [31:0] rd);
      @(posedge ref_clk);
      reg_req <= '{1'b1, w, s, sec, pv, wd};
      @(posedge ref_clk);
      reg_req.valid <= 1'b0;
      reg_req.wdata <= ~wd;
      @(negedge ref_clk);
      u = reg_undef;
      rd = reg_rdata;
   endtask
endmodule // dafs_cpu

// ---- tb/tb.sv ----
// Testbench for the domain access and fault record block.
`timescale 1ns/1ps
module tb;
   import dafs_pkg::*;
   typedef struct packed {logic s; logic [3:0] d; logic a, f, x; logic [2:0] e;} dafs_row_t;
   localparam dafs_row_t ROWS [9] = '{
      '{1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 3'h4}, '{1'b0, 4'h1, 1'b1, 1'b0, 1'b0, 3'h0},
      '{1'b0, 4'h1, 1'b0, 1'b0, 1'b0, 3'h2}, '{1'b0, 4'h2, 1'b1, 1'b0, 1'b0, 3'h4},
      '{1'b0, 4'h3, 1'b0, 1'b0, 1'b0, 3'h0}, '{1'b0, 4'h3, 1'b1, 1'b1, 1'b1, 3'h0},
      '{1'b0, 4'h1, 1'b1, 1'b1, 1'b1, 3'h1}, '{1'b0, 4'hF, 1'b0, 1'b0, 1'b0, 3'h0},
      '{1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 3'h4}};
   logic          ref_clk, rst_n, lock, undef_o, rvalid_o, cv, df, pf, xf, u;
   logic [31:0]   rdata_o, rd;
   logic [2:0]    r;
   dafs_reg_req_t reg_req;
   dafs_chk_req_t chk_req;
   dafs_abort_t   abort_in;
   int            error_cnt = 0, total_checks = 0;
   dafs_top i_dafs_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .secure_register_write_lock(lock), .reg_req(reg_req), .reg_undef(undef_o),
      .reg_rvalid(rvalid_o), .reg_rdata(rdata_o), .chk_req(chk_req), .chk_valid(cv),
      .chk_domain_fault(df), .chk_perm_fault(pf), .chk_xn_fault(xf), .abort_in(abort_in));
   dafs_cpu i_dafs_cpu (.ref_clk(ref_clk), .reg_req(reg_req), .reg_undef(undef_o),
      .reg_rdata(rdata_o));
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdr(input dafs_reg_sel_t s, input logic sec, input logic [31:0] e);
      i_dafs_cpu.acc(1'b0, s, sec, 1'b1, 32'h0000_0000, u, rd);
      cmp(rd, e);
      cmp({31'h0, rvalid_o}, 32'h0000_0001);
   endtask
   task automatic abt(input dafs_abort_t a);
      @(posedge ref_clk);
      abort_in <= a;
      @(posedge ref_clk);
      abort_in.valid <= 1'b0;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #2000;
      error_cnt++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      lock = 1'b0;
      chk_req = '0;
      abort_in = '0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdr(DAFS_REG_DOMPERM, 1'b0, 32'h0000_0000);
      rdr(DAFS_REG_FAULT, 1'b0, 32'h0000_0000);
      i_dafs_cpu.acc(1'b1, DAFS_REG_DOMPERM, 1'b0, 1'b1, 32'hC000_00E4, u, rd);
      rdr(DAFS_REG_DOMPERM, 1'b0, 32'hC000_00E4);
      rdr(DAFS_REG_DOMPERM, 1'b1, 32'h0000_0000);
      foreach (ROWS[i]) begin
         @(posedge ref_clk);
         abort_in.secure <= ROWS[i].s;
         chk_req <= '{1'b1, ROWS[i].d, {1'b0, ROWS[i].a}, ROWS[i].f, ROWS[i].x};
         @(posedge ref_clk);
         chk_req.valid <= 1'b0;
         @(negedge ref_clk);
         r = {df, pf, xf};
         cmp({31'h0, cv}, 32'h0000_0001);
         cmp({29'h0, r}, {29'h0, ROWS[i].e});
      end
      i_dafs_cpu.acc(1'b0, DAFS_REG_DOMPERM, 1'b0, 1'b0, 32'h0000_0000, u, rd);
      cmp({31'h0, u}, 32'h0000_0001);
      cmp({31'h0, rvalid_o}, 32'h0000_0000);
      i_dafs_cpu.acc(1'b1, DAFS_REG_DOMPERM, 1'b1, 1'b0, 32'hFFFF_FFFF, u, rd);
      cmp({31'h0, u}, 32'h0000_0001);
      @(posedge ref_clk);
      lock <= 1'b1;
      repeat (3) @(posedge ref_clk);
      i_dafs_cpu.acc(1'b1, DAFS_REG_DOMPERM, 1'b1, 1'b1, 32'h5555_5555, u, rd);
      cmp({31'h0, u}, 32'h0000_0001);
      rdr(DAFS_REG_DOMPERM, 1'b1, 32'h0000_0000);
      @(posedge ref_clk);
      lock <= 1'b0;
      abt('{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h8, 4'h5});
      rdr(DAFS_REG_FAULT, 1'b0, 32'h0000_1C58);
      rdr(DAFS_REG_FAULT, 1'b1, 32'h0000_0000);
      abt('{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hD, 4'h3});
      rdr(DAFS_REG_FAULT, 1'b0, 32'h0000_003D);
      abt('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h6, 4'h2});
      i_dafs_cpu.acc(1'b0, DAFS_REG_FAULT, 1'b0, 1'b1, 32'h0000_0000, u, rd);
      cmp(rd & FS_IMPMASK, 32'h0000_0006);
      i_dafs_cpu.acc(1'b1, DAFS_REG_FAULT, 1'b0, 1'b1, 32'hFFFF_FFFF, u, rd);
      rdr(DAFS_REG_FAULT, 1'b0, 32'h0000_1CFF);
      end_sim();
   end
endmodule // tb
